/* File: common/svmon_pkg.sv */
/*
  Package for the supply voltage monitor: register map, field layout,
  reset values, threshold tables.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// What this block does
// - Control bits 3:0 hold a writable 4-bit threshold code that picks the comparator threshold.
// - With the range bit at one the codes step by 75 mV from 2.550 V at code 0 to 3.675 V at code 15.
// - With the range bit at zero the codes step by 50 mV from 1.70 V at code 0 to 2.45 V at code 15.
// - Control bit 4 is the writable range select, 0 for low range and 1 for high range, low after reset.
// - Read-only bit 5 reads one while the supply is above the configured threshold, else zero.
// - After reset the code is 0x2 in the low range, a threshold of 1.8 V.
// - In deep sleep the monitor is inactive and gives no status updates and no interrupts.
// - The low-supply flag is raised when the status bit falls from one to zero.
// - The flag is set for each of the two transceivers only when that transceiver is not asleep.
// - No interrupt is raised if the supply was low from power-on and status has never been one.
// - A new threshold still above the supply, with status staying zero, raises no interrupt.
package svmon_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h8;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         CODE_W          = 4;
  localparam int         RANGE_BIT       = 4;
  localparam int         ABOVE_BIT       = 5;
  localparam int         NUM_TRX         = 2;
  localparam logic [3:0] CODE_RESET      = 4'h2;
  localparam logic       RANGE_RESET     = 1'b0;
  localparam logic [1:0] MASK_RESET      = 2'h3;

  // ****************************************
  // Threshold tables, in millivolts
  // ****************************************
  localparam logic [11:0] HIGH_BASE_MV   = 12'h9F6;
  localparam logic [11:0] HIGH_STEP_MV   = 12'h04B;
  localparam logic [11:0] LOW_BASE_MV    = 12'h6A4;
  localparam logic [11:0] LOW_STEP_MV    = 12'h032;

  typedef enum logic [1:0] {
    SVMON_ST_IDLE,
    SVMON_ST_ARMED,
    SVMON_ST_LOW
  } svmon_state_t;

  // Threshold in mV for a code and range
  function automatic logic [11:0] svmon_thresh_mv(input logic [3:0] code, input logic high);
    logic [11:0] step;
    step = high ? HIGH_STEP_MV : LOW_STEP_MV;
    return (high ? HIGH_BASE_MV : LOW_BASE_MV) + 12'(step * {8'h00, code});
  endfunction

endpackage

/* File: rtl/svmon_sync.sv */
/*
  Two-flip-flop synchroniser for the comparator level.
  Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ns
module svmon_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;

  // First stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* File: rtl/svmon_top.sv */
/*
  Supply voltage monitor: control register, status, low-supply interrupt
  for two transceivers, Wishbone classic slave.
  Assumes the analogue comparator takes the threshold code and range and
  returns an asynchronous above-threshold level; sleep inputs are synchronous.
*/
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module svmon_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cmp_above_i,
  input  wire logic        deep_sleep_i,
  input  wire logic [1:0]  trx_sleep_i,
  output logic [3:0]       threshold_code_o,
  output logic             high_range_select_o,
  output logic [11:0]      threshold_mv_o,
  output logic             monitor_enable_o,
  output logic [1:0]       low_supply_irq_flag_o,
  output logic             irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [3:0]             threshold_code;
  logic                   high_range_select;
  logic                   supply_above_flag;
  logic                   above_sync;
  logic                   above_prev;
  logic                   ever_above;
  logic [1:0]             low_supply_irq_flag;
  logic [1:0]             low_supply_irq_mask;
  logic                   fall_event;
  logic                   bus_req;
  logic                   wr_lane0;
  logic [1:0]             next_flag;
  svmon_pkg::svmon_state_t state;

  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

  // ****************************************
  // Comparator crossing
  // ****************************************
  svmon_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (cmp_above_i),
    .sync_o  (above_sync)
  );

  // ****************************************
  // Control register
  // ****************************************
  // Code and range; bits 7:6 have no storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_code    <= svmon_pkg::CODE_RESET;
      high_range_select <= svmon_pkg::RANGE_RESET;
    end else if (wr_lane0 && wb_adr_i == svmon_pkg::ADDR_CONTROL) begin
      threshold_code    <= wb_dat_i[svmon_pkg::CODE_W-1:0];
      high_range_select <= wb_dat_i[svmon_pkg::RANGE_BIT];
    end
  end

  // Threshold seen by the comparator, also as millivolts for the analogue trim
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_mv_o <= svmon_pkg::svmon_thresh_mv(svmon_pkg::CODE_RESET, svmon_pkg::RANGE_RESET);
    end else begin
      threshold_mv_o <= svmon_pkg::svmon_thresh_mv(threshold_code, high_range_select);
    end
  end

  assign threshold_code_o    = threshold_code;
  assign high_range_select_o = high_range_select;
  assign monitor_enable_o    = !deep_sleep_i;

  // ****************************************
  // Status and edge detection
  // ****************************************
  // Status frozen in deep sleep since the comparator is unpowered there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_above_flag <= 1'b0;
      above_prev        <= 1'b0;
      ever_above        <= 1'b0;
    end else if (!deep_sleep_i) begin
      supply_above_flag <= above_sync;
      above_prev        <= supply_above_flag;
      if (supply_above_flag) begin
        ever_above <= 1'b1;
      end
    end
  end

  // Only a true one-to-zero fall counts; staying low after a write is no event
  assign fall_event = !deep_sleep_i && above_prev && !supply_above_flag;

  // Small tracker of the monitor's view of the supply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= svmon_pkg::SVMON_ST_IDLE;
    end else begin
      case (state)
        svmon_pkg::SVMON_ST_IDLE: begin
          if (supply_above_flag) begin
            state <= svmon_pkg::SVMON_ST_ARMED;
          end
        end
        svmon_pkg::SVMON_ST_ARMED: begin
          if (fall_event) begin
            state <= svmon_pkg::SVMON_ST_LOW;
          end
        end
        svmon_pkg::SVMON_ST_LOW: begin
          if (supply_above_flag) begin
            state <= svmon_pkg::SVMON_ST_ARMED;
          end
        end
        default: begin
          state <= svmon_pkg::SVMON_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always_comb begin
    next_flag = low_supply_irq_flag;
    if (wr_lane0 && wb_adr_i == svmon_pkg::ADDR_IRQ_STATUS) begin
      next_flag = next_flag & ~wb_dat_i[svmon_pkg::NUM_TRX-1:0];
    end
    if (fall_event) begin
      next_flag = next_flag | ~trx_sleep_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_supply_irq_flag <= '0;
    end else begin
      low_supply_irq_flag <= next_flag;
    end
  end

  // Mask is a plain enable; noisy supplies are tamed by software clearing it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_supply_irq_mask <= svmon_pkg::MASK_RESET;
    end else if (wr_lane0 && wb_adr_i == svmon_pkg::ADDR_IRQ_MASK) begin
      low_supply_irq_mask <= wb_dat_i[svmon_pkg::NUM_TRX-1:0];
    end
  end

  assign low_supply_irq_flag_o = low_supply_irq_flag;
  assign irq_o = |(low_supply_irq_flag & low_supply_irq_mask);

  // ****************************************
  // Wishbone answer
  // ****************************************
  // One-cycle ack, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == svmon_pkg::ADDR_CONTROL) begin
          wb_dat_o <= {26'h0, supply_above_flag, high_range_select, threshold_code};
        end else if (wb_adr_i == svmon_pkg::ADDR_IRQ_STATUS) begin
          wb_dat_o <= {30'h0, low_supply_irq_flag};
        end else if (wb_adr_i == svmon_pkg::ADDR_IRQ_MASK) begin
          wb_dat_o <= {30'h0, low_supply_irq_mask};
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Reset values of the control fields and of the derived threshold
  a_reset_code_default: assert property (@(posedge clk_i)
    $past(rst_i) |-> threshold_code == svmon_pkg::CODE_RESET && !high_range_select)
    else $error("control reset value wrong");

  a_mv_reset_value: assert property (@(posedge clk_i)
    $past(rst_i) |-> threshold_mv_o == 12'h708)
    else $error("threshold reset value wrong");

  // Control writes land on the taking edge, lane 0 only
  a_code_write_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == svmon_pkg::ADDR_CONTROL |=> threshold_code == $past(wb_dat_i[svmon_pkg::CODE_W-1:0]))
    else $error("threshold code not written");

  a_range_write_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == svmon_pkg::ADDR_CONTROL |=> high_range_select == $past(wb_dat_i[svmon_pkg::RANGE_BIT]))
    else $error("range bit not written");

  a_lane_gated_write: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && wb_we_i && !wb_sel_i[0] |=> $stable(threshold_code) && $stable(high_range_select))
    else $error("control written without lane 0");

  // Table end points and the reset-code threshold; the ladder is only trusted once code and range sit still
  a_high_table: assert property (@(posedge clk_i) disable iff (rst_i)
    high_range_select && threshold_code == 4'hF && $stable(threshold_code) && $stable(high_range_select)
    |=> threshold_mv_o == 12'hE5B)
    else $error("high range top wrong");

  a_low_table: assert property (@(posedge clk_i) disable iff (rst_i)
    !high_range_select && threshold_code == 4'hF && $stable(threshold_code) && $stable(high_range_select)
    |=> threshold_mv_o == 12'h992)
    else $error("low range top wrong");

  a_high_base: assert property (@(posedge clk_i) disable iff (rst_i)
    high_range_select && threshold_code == 4'h0 && $stable(threshold_code) && $stable(high_range_select)
    |=> threshold_mv_o == 12'h9F6)
    else $error("high range bottom wrong");

  a_low_base: assert property (@(posedge clk_i) disable iff (rst_i)
    !high_range_select && threshold_code == 4'h0 && $stable(threshold_code) && $stable(high_range_select)
    |=> threshold_mv_o == 12'h6A4)
    else $error("low range bottom wrong");

  a_default_thresh: assert property (@(posedge clk_i) disable iff (rst_i)
    !high_range_select && threshold_code == svmon_pkg::CODE_RESET && $stable(threshold_code)
    && $stable(high_range_select) |=> threshold_mv_o == 12'h708)
    else $error("default threshold wrong");

  // Status path
  a_status_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    !deep_sleep_i |=> supply_above_flag == $past(above_sync))
    else $error("status not following comparator");

  a_sync_two_stage: assert property (@(posedge clk_i) disable iff (rst_i)
    !deep_sleep_i [*3] |-> supply_above_flag == $past(cmp_above_i, 3))
    else $error("synchroniser depth wrong");

  a_sleep_status_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    deep_sleep_i |=> $stable(supply_above_flag))
    else $error("status moved in deep sleep");

  // Interrupt flags
  a_sleep_no_event: assert property (@(posedge clk_i) disable iff (rst_i)
    deep_sleep_i |=> $stable(low_supply_irq_flag) || $past(wr_lane0))
    else $error("flag set in deep sleep");

  a_fall_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_event && !trx_sleep_i[0] |=> low_supply_irq_flag[0])
    else $error("fall did not set flag");

  a_fall_sets_second: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_event && !trx_sleep_i[1] |=> low_supply_irq_flag[1])
    else $error("fall did not set second flag");

  a_asleep_trx_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    !low_supply_irq_flag[1] && trx_sleep_i[1] |=> !low_supply_irq_flag[1])
    else $error("sleeping transceiver flagged");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    low_supply_irq_flag[0] && !(wr_lane0 && wb_adr_i == svmon_pkg::ADDR_IRQ_STATUS && wb_dat_i[0])
    |=> low_supply_irq_flag[0])
    else $error("flag lost without clear");

  a_never_above_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !ever_above |-> !fall_event)
    else $error("event without prior high status");

  // A threshold write while the status is already low must stay quiet
  a_write_no_event: assert property (@(posedge clk_i) disable iff (rst_i)
    !deep_sleep_i && !supply_above_flag && wr_lane0 && wb_adr_i == svmon_pkg::ADDR_CONTROL |=> !fall_event)
    else $error("event after threshold write");

  // Tracker and edge detector must agree on every fall
  a_fall_when_armed: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_event |-> state == svmon_pkg::SVMON_ST_ARMED)
    else $error("fall seen while not armed");

  a_low_after_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_event |=> state == svmon_pkg::SVMON_ST_LOW)
    else $error("tracker missed a fall");

  a_mask_write_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == svmon_pkg::ADDR_IRQ_MASK |=> low_supply_irq_mask == $past(wb_dat_i[1:0]))
    else $error("mask not written");

  // Read-back of the control register
  a_top_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(bus_req && !wb_we_i && wb_adr_i == svmon_pkg::ADDR_CONTROL) |-> wb_dat_o[7:6] == 2'b00)
    else $error("reserved bits not zero");

  a_status_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(bus_req && !wb_we_i && wb_adr_i == svmon_pkg::ADDR_CONTROL)
    |-> wb_dat_o[svmon_pkg::ABOVE_BIT] == $past(supply_above_flag))
    else $error("status bit read back wrong");

  a_code_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(bus_req && !wb_we_i && wb_adr_i == svmon_pkg::ADDR_CONTROL)
    |-> wb_dat_o[svmon_pkg::CODE_W-1:0] == $past(threshold_code))
    else $error("code read back wrong");

  a_range_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(bus_req && !wb_we_i && wb_adr_i == svmon_pkg::ADDR_CONTROL)
    |-> wb_dat_o[svmon_pkg::RANGE_BIT] == $past(high_range_select))
    else $error("range read back wrong");

endmodule

/* File: testbench/svmon_cmp_model.sv */
/*
  Comparator model: compares the bench's supply level with the threshold ladder.
  Assumes code and range come straight from the design's comparator outputs.
*/
`timescale 1ns/1ns
module svmon_cmp_model (
  input  wire logic [3:0]  code_i,
  input  wire logic        high_i,
  input  wire logic [11:0] supply_mv_i,
  output logic             above_o
);
  logic [11:0] th_mv;
  // Ladder of thresholds, kept apart from the design's own function
  assign th_mv = high_i ? 12'h9F6 + 12'h04B * {8'h00, code_i} : 12'h6A4 + 12'h032 * {8'h00, code_i};
  // Strictly above reads as one; level changes at once, no clock
  assign above_o = supply_mv_i > th_mv;
endmodule

/* File: testbench/test_supply_voltage_monitor.sv */
/*
  Self-checking bench for the supply monitor: register rows, interrupts, sleep, reset.
  Assumes the comparator model drives cmp_above_i from the bench's supply level.
*/
`timescale 1ns/1ns
module test_supply_voltage_monitor;
  typedef struct {logic [7:0] w; logic [7:0] r; logic [11:0] mv;} svmon_row_t;
  logic        clk, rst, cyc, stb, we, ack, above, dsleep, hi, mon_en, irq;
  logic [3:0]  adr, sel, code;
  logic [31:0] wdat, rdat, q;
  logic [11:0] supply, mv;
  logic [1:0]  tsleep, flags;
  int          err_total, n_checks;
  // Write value, read-back value, threshold in mV; supply stays below all of them
  svmon_row_t  rows [6] = '{'{8'h00, 8'h00, 12'h6A4}, '{8'hCF, 8'h0F, 12'h992}, '{8'h30, 8'h10, 12'h9F6},
                           '{8'h1F, 8'h1F, 12'hE5B}, '{8'h27, 8'h07, 12'h802}, '{8'h1A, 8'h1A, 12'hCE4}};

  svmon_top svmon_top_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_above_i(above), .deep_sleep_i(dsleep), .trx_sleep_i(tsleep), .threshold_code_o(code),
    .high_range_select_o(hi), .threshold_mv_o(mv), .monitor_enable_o(mon_en),
    .low_supply_irq_flag_o(flags), .irq_o(irq));
  svmon_cmp_model svmon_cmp_model_i (.code_i(code), .high_i(hi), .supply_mv_i(supply), .above_o(above));

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is under two hundred cycles; this bound only catches a hang
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    close_out();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is seen high at a rising edge, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hF, 32'h0);
    chk("read data", e, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'h1, d);
  endtask
  task automatic drive(input logic [11:0] s, input logic d, input logic [1:0] t);
    @(posedge clk);
    supply <= s;
    dsleep <= d;
    tsleep <= t;
  endtask
  // Lands on a falling edge so that outputs have settled
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, cyc, stb, we, dsleep} = 5'h1F & 5'h10;
    {adr, sel, wdat} = 40'h0;
    supply = 12'h5DC;
    tsleep = 2'h0;
    err_total = 0;
    n_checks = 0;
    do_reset();
    chk("threshold mv", 32'h708, {20'h0, mv});
    chk("enable", 32'h1, {31'h0, mon_en});
    rd(4'h0, 32'h02);
    rd(4'h8, 32'h03);
    foreach (rows[i]) begin
      wr(4'h0, {24'h0, rows[i].w});
      rd(4'h0, {24'h0, rows[i].r});
      tick(1);
      chk("threshold mv", {20'h0, rows[i].mv}, {20'h0, mv});
      chk("code and range", {27'h0, rows[i].r[4:0]}, {27'h0, hi, code});
    end
    rd(4'h4, 32'h0);
    wb(1'b1, 4'h0, 4'h0, 32'h05);
    rd(4'h0, 32'h1A);
    wr(4'hC, 32'hFF);
    rd(4'hC, 32'h0);
    // Supply rises over 1.8 V, then falls while the second transceiver sleeps
    wr(4'h0, 32'h02);
    drive(12'h7D0, 1'b0, 2'b10);
    tick(5);
    rd(4'h0, 32'h22);
    drive(12'h5DC, 1'b0, 2'b10);
    tick(5);
    chk("flags", 32'h1, {30'h0, flags});
    chk("irq", 32'h1, {31'h0, irq});
    rd(4'h4, 32'h1);
    wr(4'h4, 32'h1);
    tick(1);
    chk("irq", 32'h0, {31'h0, irq});
    // Host masks the event while the supply hovers near the threshold
    wr(4'h8, 32'h0);
    drive(12'h7D0, 1'b0, 2'b00);
    tick(5);
    drive(12'h5DC, 1'b0, 2'b00);
    tick(5);
    chk("flags", 32'h3, {30'h0, flags});
    chk("irq", 32'h0, {31'h0, irq});
    wr(4'h8, 32'h2);
    tick(1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h4, 32'h3);
    tick(1);
    chk("irq", 32'h0, {31'h0, irq});
    // Fall during deep sleep must stay quiet
    drive(12'h7D0, 1'b0, 2'b00);
    tick(5);
    drive(12'h5DC, 1'b1, 2'b00);
    tick(6);
    chk("enable", 32'h0, {31'h0, mon_en});
    chk("flags", 32'h0, {30'h0, flags});
    drive(12'h5DC, 1'b0, 2'b00);
    do_reset();
    rd(4'h0, 32'h02);
    chk("flags", 32'h0, {30'h0, flags});
    chk("threshold mv", 32'h708, {20'h0, mv});
    close_out();
  end
endmodule
